/* rtl/wtas_pkg.sv */
// Purpose: shared constants and types of the watch timekeeping block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: all register offsets are byte addresses
package wtas_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIME = 8'h04;
  localparam logic [7:0] OFF_DAY = 8'h08;
  localparam logic [7:0] OFF_ALM1_TIME = 8'h0C;
  localparam logic [7:0] OFF_ALM2_TIME = 8'h10;
  localparam logic [7:0] OFF_ALM2_DAY = 8'h14;
  localparam logic [7:0] OFF_SWATCH = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;

  // field positions of a time word
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HOUR_LSB = 16;

  // control bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SW_RUN = 1;

  // status and mask bit positions
  localparam int EV_SEC = 0;
  localparam int EV_MIN = 1;
  localparam int EV_HOUR = 2;
  localparam int EV_DAY = 3;
  localparam int EV_ALM1 = 4;
  localparam int EV_ALM2 = 5;
  localparam int EV_SWATCH = 6;
  localparam int EV_NUM = 7;

  // counter limits
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam int DAY_W = 15;

  // watch crystal rate and wanted tick rate
  localparam int WATCH_HZ = 32768;
  localparam int TICK_HZ = 1;
  localparam int PRESCALE = WATCH_HZ / TICK_HZ;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic RST_RUN = 1'b1;

  // time of day carried as one unit
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } wtas_time_s;
endpackage

/* rtl/wtas_rtc.sv */
// Purpose: watch timekeeping with two alarms, countdown stopwatch and tick interrupts
// Assumes: clk 40 MHz, watch crystal square wave on watch_crystal_input, APB master
// Notes: one interrupt output, sticky status cleared by writing ones
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module wtas_rtc #(
  parameter int PRESCALE = wtas_pkg::PRESCALE
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic watch_crystal_input,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // register map, one aligned word each
  // 0x00 control: bit0 run, bit1 stopwatch busy (read only)
  // 0x04 time of day: sec [5:0], min [13:8], hour [20:16]
  // 0x08 day count [14:0]
  // 0x0C alarm one time of day
  // 0x10 alarm two time of day
  // 0x14 alarm two day [14:0]
  // 0x18 stopwatch: a write loads and starts it, a read gives the count
  // 0x1C status, write ones to clear
  // 0x20 mask, same layout as status, a set bit enables the interrupt
  // any other offset answers with pslverr, reads zero and ignores writes

  // status and mask bits
  // bit0 second, bit1 minute, bit2 hour, bit3 day
  // bit4 alarm one, bit5 alarm two, bit6 stopwatch underflow
  // status bits set whatever the mask says; the mask only gates irq

  // timing seen from the bus
  // the answer comes in the first access cycle, never a wait state
  // a crystal edge reaches the prescaler about three clk later
  // counters move two clk after the synchronised edge
  // alarm flags follow one clk after the counters
  // irq rises on the same edge as the status flag that causes it

  // reset state
  // all outputs low, run set so time starts counting at once
  // counters, alarms, mask and status all zero
  // the stopwatch is idle until software loads it

  // limitations
  // time writes are stored unchecked; a field above its last state
  // only returns to zero through the full count of its width
  // the day counter rolls from 0x7FFF to zero with no flag of its own
  // the prescaler phase is kept while run is clear, so the first
  // second after a restart can be short
  // a time write in the tick cycle wins and that tick is lost

  // wrap-around increment shared by the second and minute counters
  function automatic logic [5:0] wtas_wrap_inc(input logic [5:0] val, input logic [5:0] last);
    logic [5:0] res;
    res = (val == last) ? 6'h00 : val + 6'h01;
    return res;
  endfunction

  // watch crystal synchroniser, the first stage feeds only the second
  // the third stage only serves edge detection; zero at reset means a
  // crystal that is already high gives one false rising edge just after reset
  logic xin_s1;
  logic xin_s2;
  logic xin_s3;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xin_s1 <= 1'b0;
      xin_s2 <= 1'b0;
      xin_s3 <= 1'b0;
    end
    else
    begin
      xin_s1 <= watch_crystal_input;
      xin_s2 <= xin_s1;
      xin_s3 <= xin_s2;
    end
  end
  wire xin_rise = xin_s2 & ~xin_s3;

  // control state
  logic run;
  logic sw_run;
  wtas_pkg::wtas_time_s now;
  logic [wtas_pkg::DAY_W-1:0] day;
  wtas_pkg::wtas_time_s alm1;
  wtas_pkg::wtas_time_s alm2;
  logic [wtas_pkg::DAY_W-1:0] alm2_day;
  logic [31:0] swatch;
  logic [wtas_pkg::EV_NUM-1:0] status;
  logic [wtas_pkg::EV_NUM-1:0] mask;
  logic [15:0] presc;
  logic tick;
  logic tick_q;

  // apb decode
  // exact offset compare, so unaligned addresses land in the error path
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == wtas_pkg::OFF_CTRL;
  wire hit_time = paddr == wtas_pkg::OFF_TIME;
  wire hit_day = paddr == wtas_pkg::OFF_DAY;
  wire hit_alm1 = paddr == wtas_pkg::OFF_ALM1_TIME;
  wire hit_alm2 = paddr == wtas_pkg::OFF_ALM2_TIME;
  wire hit_alm2d = paddr == wtas_pkg::OFF_ALM2_DAY;
  wire hit_sw = paddr == wtas_pkg::OFF_SWATCH;
  wire hit_stat = paddr == wtas_pkg::OFF_STATUS;
  wire hit_mask = paddr == wtas_pkg::OFF_MASK;
  wire hit_any = hit_ctrl | hit_time | hit_day | hit_alm1 | hit_alm2 | hit_alm2d | hit_sw | hit_stat | hit_mask;

  // time of day to and from the register word
  function automatic logic [31:0] wtas_pack(input wtas_pkg::wtas_time_s t);
    logic [31:0] w;
    w = wtas_pkg::RST_WORD;
    w[wtas_pkg::SEC_LSB +: 6] = t.sec;
    w[wtas_pkg::MIN_LSB +: 6] = t.min;
    w[wtas_pkg::HOUR_LSB +: 5] = t.hour;
    return w;
  endfunction
  function automatic wtas_pkg::wtas_time_s wtas_unpack(input logic [31:0] w);
    wtas_pkg::wtas_time_s t;
    t.sec = w[wtas_pkg::SEC_LSB +: 6];
    t.min = w[wtas_pkg::MIN_LSB +: 6];
    t.hour = w[wtas_pkg::HOUR_LSB +: 5];
    return t;
  endfunction

  // read data selection
  wire [31:0] ctrl_word = {30'h0000_0000, sw_run, run};
  wire [31:0] day_word = {17'h0_0000, day};
  wire [31:0] alm2d_word = {17'h0_0000, alm2_day};
  wire [31:0] stat_word = {25'h000_0000, status};
  wire [31:0] mask_word = {25'h000_0000, mask};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_time ? wtas_pack(now) :
                        hit_day ? day_word :
                        hit_alm1 ? wtas_pack(alm1) :
                        hit_alm2 ? wtas_pack(alm2) :
                        hit_alm2d ? alm2d_word :
                        hit_sw ? swatch :
                        hit_stat ? stat_word :
                        hit_mask ? mask_word : wtas_pkg::RST_WORD;

  // one-wait-free apb answer: ready, data and error registered in the setup cycle
  // read data is zero outside a read answer so a bus mux can simply or it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      prdata <= wtas_pkg::RST_WORD;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= (setup & ~pwrite) ? rd_word : wtas_pkg::RST_WORD;
      pslverr <= setup & ~hit_any;
    end
  end

  // prescaler counts rising crystal edges, and only while run is set
  // counting edges of the synchronised crystal costs three clk of lag
  // but keeps the whole block on one clock
  wire presc_wrap = presc == 16'(PRESCALE - 1);
  wire next_tick = run & xin_rise & presc_wrap;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      presc <= 16'h0000;
      tick <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      if (run & xin_rise)
        presc <= presc_wrap ? 16'h0000 : presc + 16'h0001;
      tick <= next_tick;
      tick_q <= tick;
    end
  end

  // carry chain across the time counters
  wire sec_wrap = tick & (now.sec == wtas_pkg::SEC_LAST);
  wire min_wrap = sec_wrap & (now.min == wtas_pkg::MIN_LAST);
  wire hour_wrap = min_wrap & (now.hour == wtas_pkg::HOUR_LAST);
  wire [4:0] hour_inc = (now.hour == wtas_pkg::HOUR_LAST) ? 5'h00 : now.hour + 5'h01;

  // a time write swallows the tick, so it must not carry into the day
  wire time_wr = wr_en & hit_time;

  // time and day counters; a software write beats the tick in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      now <= '0;
      day <= '0;
    end
    else
    begin
      if (wr_en & hit_time)
        now <= wtas_unpack(pwdata);
      else if (tick)
      begin
        now.sec <= wtas_wrap_inc(now.sec, wtas_pkg::SEC_LAST);
        if (sec_wrap)
          now.min <= wtas_wrap_inc(now.min, wtas_pkg::MIN_LAST);
        if (min_wrap)
          now.hour <= hour_inc;
      end
      if (wr_en & hit_day)
        day <= pwdata[wtas_pkg::DAY_W-1:0];
      else if (hour_wrap & ~time_wr)
        day <= day + 15'h0001;
    end
  end

  // alarm settings and control
  // clearing run freezes time for a consistent read of all fields
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alm1 <= '0;
      alm2 <= '0;
      alm2_day <= '0;
      mask <= '0;
      run <= wtas_pkg::RST_RUN;
    end
    else if (wr_en)
    begin
      if (hit_alm1)
        alm1 <= wtas_unpack(pwdata);
      if (hit_alm2)
        alm2 <= wtas_unpack(pwdata);
      if (hit_alm2d)
        alm2_day <= pwdata[wtas_pkg::DAY_W-1:0];
      if (hit_mask)
        mask <= pwdata[wtas_pkg::EV_NUM-1:0];
      if (hit_ctrl)
        run <= pwdata[wtas_pkg::CTRL_RUN];
    end
  end

  // stopwatch: a write loads and starts it, reaching zero and ticking again underflows
  // it only counts while run is set, since it shares the one-second tick
  wire sw_under = tick & sw_run & (swatch == 32'h0000_0000);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      swatch <= wtas_pkg::RST_WORD;
      sw_run <= 1'b0;
    end
    else if (wr_en & hit_sw)
    begin
      swatch <= pwdata;
      sw_run <= 1'b1;
    end
    else if (sw_under)
      sw_run <= 1'b0;
    else if (tick & sw_run)
      swatch <= swatch - 32'h0000_0001;
  end

  // alarms are checked one cycle after the tick so each match fires once
  // comparing only after a tick means a time write fires an alarm only if it lands in the tick cycle
  wire alm1_hit = tick_q & (now == alm1);
  wire alm2_hit = tick_q & (now == alm2) & (day == alm2_day);

  // event vector; tick events come from the carry chain
  wire [wtas_pkg::EV_NUM-1:0] ev_set = {sw_under, alm2_hit, alm1_hit, hour_wrap, min_wrap, sec_wrap, tick};
  wire [wtas_pkg::EV_NUM-1:0] ev_clr = (wr_en & hit_stat) ? pwdata[wtas_pkg::EV_NUM-1:0] : '0;

  // sticky status, a new event wins over a clear in the same cycle
  // so software never loses an event that lands on its clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status <= '0;
    else
      status <= (status & ~ev_clr) | ev_set;
  end

  // interrupt level from unmasked pending bits; mask acts as the enable
  // built from the next status value so irq tracks status with no lag
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(((status & ~ev_clr) | ev_set) & mask);
  end

endmodule

/* tb/wtas_rtc_props.sv */
// Purpose: bus answer and interrupt checks for wtas_rtc
// Assumes: registered APB answer in the first access cycle
// Notes: bound to every wtas_rtc instance
`timescale 1ns/1ps
module wtas_rtc_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // setup phase and quiet outputs
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_idle_out;
    !pready && !irq;
  endsequence
  // bus answer timing and decode
  a_rdy_setup: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_rdy_pulse: assert property (pready |=> !pready) else $error("answer longer than one cycle");
  a_err_rdy: assert property (pslverr |-> pready) else $error("error without answer");
  a_rd_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("read data not zero");
  a_err_unmap: assert property (pready && paddr > 8'h20 |-> pslverr) else $error("unmapped not refused");
  a_ok_map: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  // quiet outputs straight after reset
  a_rst_quiet: assert property ($rose(resetn) |-> s_idle_out) else $error("outputs busy after reset");
  // only a bus write can drop the sticky interrupt
  a_irq_sticky: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 1))
    else $error("interrupt dropped without a write");
endmodule

bind wtas_rtc wtas_rtc_props u_props (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .irq);

/* tb/tb.sv */
// Purpose: self-checking bench for wtas_rtc
// Assumes: PRESCALE 4 and a fast crystal stand-in, one tick every 32 clk
// Notes: reset check first, then register rows, rollover, clear and stopwatch cases
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} wtas_row_s;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] xc;
  int miscompares, tests_run, n;
  wtas_row_s rows[6];
  wtas_rtc #(.PRESCALE(4)) dut (.clk(clk), .resetn(resetn), .watch_crystal_input(xc[2]), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // crystal stand-in, short period keeps the run brief
  always @(posedge clk) xc <= xc + 3'h1;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1)
      miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1)
      miscompares++;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog, the whole run needs about 215 cycles
  initial
  begin
    #(25 * 6000);
    miscompares++;
    summarize();
  end
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    xc = 3'h0;
    rows = '{'{wtas_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0}, '{wtas_pkg::OFF_TIME, 32'h00173B3B, 32'h00173B3B, 1'b0},
      '{wtas_pkg::OFF_DAY, 32'h7FFF, 32'h7FFF, 1'b0}, '{wtas_pkg::OFF_MASK, 32'h1, 32'h1, 1'b0},
      '{8'h24, 32'hFFFFFFFF, 32'h0, 1'b1}, '{wtas_pkg::OFF_STATUS, 32'h7F, 32'h0, 1'b0}};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("irq after reset", irq, 1'b0);
    apb(1'b0, wtas_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    $display("test reset done");
    // stopped counters make every read-back stable
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk("write refusal", er, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      chk("read back", rd, rows[i].r);
    end
    $display("test register rows done");
    // full rollover of the time and day counters at once, alarms at zero
    apb(1'b1, wtas_pkg::OFF_CTRL, 32'h1);
    wait_irq();
    apb(1'b1, wtas_pkg::OFF_CTRL, 32'h0);
    apb(1'b0, wtas_pkg::OFF_TIME, 32'h0);
    chk("time wrap", rd, 32'h0);
    apb(1'b0, wtas_pkg::OFF_DAY, 32'h0);
    chk("day wrap", rd, 32'h0);
    apb(1'b0, wtas_pkg::OFF_STATUS, 32'h0);
    chk("tick and alarm flags", rd, 32'h3F);
    apb(1'b1, wtas_pkg::OFF_STATUS, 32'h7F);
    apb(1'b0, wtas_pkg::OFF_STATUS, 32'h0);
    chk("status cleared", rd, 32'h0);
    chk("irq dropped", irq, 1'b0);
    $display("test rollover done");
    // stopwatch from 2 underflows on the third tick
    apb(1'b1, wtas_pkg::OFF_MASK, 32'h40);
    apb(1'b1, wtas_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, wtas_pkg::OFF_SWATCH, 32'h2);
    wait_irq();
    chk("stopwatch span", 32'(n > 60 && n < 100), 32'h1);
    apb(1'b0, wtas_pkg::OFF_STATUS, 32'h0);
    chk("underflow flag", rd[6], 1'b1);
    apb(1'b0, wtas_pkg::OFF_CTRL, 32'h0);
    chk("stopwatch stopped", rd[1:0], 2'h1);
    $display("test stopwatch done");
    summarize();
  end
endmodule
